// [hdl/psr_status_bank.sv]
// Processor status register bank of one compute tile.
// Assumes the tile processor issues status reads and writes one at a
// time, synchronous to core_clk, and waits for ps_ack.
//
// Functional notes
// - RAM base resets to 0x00010000; bits 31:2 writable, 1:0 read zero.
// - Vector target is vector base 31:16 joined with the event vector.
// - Tile control bit 4 resets low and enables the clock divider.
// - Bit 5 picks dynamic (all cores paused) or static divider action.
// - Boot status 23:16 shows the tile number on the switch.
// - Boot status bit 8 shows one-time-programmable boot enable.
// - Boot status 7:0 shows the sampled boot select pins.
// - Security configuration shows the security word copy, read-only.
// - Four free-running ring oscillators each have their own counter, clocked by core_clk.
// - Oscillator control bit 1 runs the two tile oscillators.
// - Oscillator control bit 0 runs the two peripheral oscillators.
// - Oscillators are asynchronous to the tile clock; counts are random.
// - Counts sit in bits 15:0 of registers 0x07 to 0x0a, read-only.
// - System reset does not clear the oscillator counters.
// - Register 0x10 holds the status snapshot taken at debugger entry.
// - Registers are reached only by status reads and writes by number.
`timescale 1ns/10ps
module psr_status_bank
  import psr_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic        pwr_on_rst_n,
  // Processor status access
  input  wire logic        ps_rd,
  input  wire logic        ps_wr,
  input  wire logic [15:0] ps_res_id,
  input  wire logic [31:0] ps_wdata,
  output logic [31:0]      ps_rdata,
  output logic             ps_ack,
  output logic             ps_err,
  // Address formation
  output logic [31:0]      ram_base_addr,
  input  wire logic        event_take,
  input  wire logic [15:0] event_vector,
  output logic [31:0]      vector_target_addr,
  // Clock divider
  input  wire logic        cores_all_paused,
  output logic             div_active,
  output logic             tile_clk_en,
  // Boot and security sources
  input  wire logic [7:0]  tile_number,
  input  wire logic        otp_boot_en,
  input  wire logic        boot_select_pin_0,
  input  wire logic        boot_select_pin_1,
  input  wire logic [5:0]  boot_select_pin_hi,
  input  wire logic        otp_sec_valid,
  input  wire logic [31:0] otp_security_word,
  // Debug snapshot
  input  wire logic        dbg_enter,
  input  wire logic [31:0] saved_status_snapshot,
  // Ring oscillators
  input  wire logic [3:0]  osc_level,
  output logic             osc_tile_run,
  output logic             osc_periph_run
);

  typedef struct packed {
    logic [31:0]          ram_base;
    logic [31:0]          vec_base;
    logic                 div_en;
    logic                 div_dyn;
    logic                 osc_tile;
    logic                 osc_periph;
    logic                 strap_done;
    logic [7:0]           boot_pins;
    logic [31:0]          sec_word;
    logic [31:0]          saved;
    logic [31:0]          vec_tgt;
    logic [PSR_DIV_W-1:0] div_cnt;
    logic                 div_tick;
    logic [31:0]          rdata;
    logic                 ack;
    logic                 err;
  } psr_bank_state_t;

  psr_bank_state_t              st_ff;
  psr_bank_state_t              nxt_st;
  logic [PSR_CNT_W-1:0]         osc_count [PSR_NUM_OSC];
  logic [PSR_NUM_OSC-1:0]       osc_run;
  logic [7:0]                   reg_num;
  logic                         tag_ok;
  logic                         req;
  logic                         known;
  logic [31:0]                  rd_val;
  logic [31:0]                  boot_word;
  logic [31:0]                  ctrl_word;
  logic [31:0]                  osc_word;
  logic                         div_on;

  // Tile oscillators are counters 0 and 1, peripheral ones 2 and 3
  assign osc_run = {st_ff.osc_periph, st_ff.osc_periph,
                    st_ff.osc_tile, st_ff.osc_tile};

  genvar gi;
  generate
    for (gi = 0; gi < PSR_NUM_OSC; gi++)
    begin : g_osc
      psr_ring_counter u_cnt (
        .core_clk     (core_clk),
        .nrst         (nrst),
        .pwr_on_rst_n (pwr_on_rst_n),
        .osc_level    (osc_level[gi]),
        .run          (osc_run[gi]),
        .count        (osc_count[gi])
      );
    end
  endgenerate

  // Request decode
  assign reg_num = ps_res_id[PSR_RES_NUM_LSB +: 8];
  assign tag_ok  = (ps_res_id[PSR_RES_NUM_LSB-1:0] == PSR_RES_TAG);
  assign req     = ps_rd | ps_wr;

  // Composite read words, reserved bits zero
  always_comb
  begin
    boot_word = PSR_ZERO;
    boot_word[PSR_TILE_LSB +: 8] = tile_number;
    boot_word[PSR_OTP_BIT] = otp_boot_en;
    boot_word[PSR_PINS_LSB +: 8] = st_ff.boot_pins;
    ctrl_word = PSR_ZERO;
    ctrl_word[PSR_DIV_EN_BIT] = st_ff.div_en;
    ctrl_word[PSR_DIV_DYN_BIT] = st_ff.div_dyn;
    osc_word = PSR_ZERO;
    osc_word[PSR_OSC_T_BIT] = st_ff.osc_tile;
    osc_word[PSR_OSC_P_BIT] = st_ff.osc_periph;
  end

  // Register number to read value
  always_comb
  begin
    known  = 1'b1;
    rd_val = PSR_ZERO;
    case (reg_num)
      PSR_RAM_BASE:
      begin
        rd_val = st_ff.ram_base & PSR_RAM_WMASK;
      end
      PSR_VEC_BASE:
      begin
        rd_val = st_ff.vec_base & PSR_VEC_WMASK;
      end
      PSR_TILE_CTRL:
      begin
        rd_val = ctrl_word;
      end
      PSR_BOOT_STAT:
      begin
        rd_val = boot_word;
      end
      PSR_SEC_CFG:
      begin
        rd_val = st_ff.sec_word;
      end
      PSR_OSC_CTRL:
      begin
        rd_val = osc_word;
      end
      PSR_OSC_TCELL:
      begin
        rd_val = {16'h0000, osc_count[0]};
      end
      PSR_OSC_TWIRE:
      begin
        rd_val = {16'h0000, osc_count[1]};
      end
      PSR_OSC_PCELL:
      begin
        rd_val = {16'h0000, osc_count[2]};
      end
      PSR_OSC_PWIRE:
      begin
        rd_val = {16'h0000, osc_count[3]};
      end
      PSR_SAVED_STAT:
      begin
        rd_val = st_ff.saved;
      end
      default:
      begin
        known  = 1'b0;
      end
    endcase
  end

  // Divider acts when enabled and, in dynamic mode, all cores paused
  assign div_on = st_ff.div_en &
                  (!st_ff.div_dyn | cores_all_paused);

  always_comb
  begin
    nxt_st      = st_ff;
    nxt_st.ack  = req;
    nxt_st.err  = req & !(tag_ok & known);
    nxt_st.rdata = PSR_ZERO;

    // Read answers in the following cycle; writes answer zero
    if (ps_rd && !ps_wr && tag_ok)
    begin
      nxt_st.rdata = rd_val;
    end

    // Writes touch only writable bits
    if (ps_wr && tag_ok)
    begin
      case (reg_num)
        PSR_RAM_BASE:
        begin
          nxt_st.ram_base = ps_wdata & PSR_RAM_WMASK;
        end
        PSR_VEC_BASE:
        begin
          nxt_st.vec_base = ps_wdata & PSR_VEC_WMASK;
        end
        PSR_TILE_CTRL:
        begin
          nxt_st.div_en  = ps_wdata[PSR_DIV_EN_BIT];
          nxt_st.div_dyn = ps_wdata[PSR_DIV_DYN_BIT];
        end
        PSR_OSC_CTRL:
        begin
          nxt_st.osc_tile   = ps_wdata[PSR_OSC_T_BIT];
          nxt_st.osc_periph = ps_wdata[PSR_OSC_P_BIT];
        end
        default:
        begin
          nxt_st.ram_base = st_ff.ram_base;
        end
      endcase
    end

    // Boot pins caught once, first cycle after reset release
    if (!st_ff.strap_done)
    begin
      nxt_st.strap_done = 1'b1;
      nxt_st.boot_pins  = {boot_select_pin_hi,
                           boot_select_pin_1,
                           boot_select_pin_0};
    end

    if (otp_sec_valid)
    begin
      nxt_st.sec_word = otp_security_word;
    end

    if (dbg_enter)
    begin
      nxt_st.saved = saved_status_snapshot;
    end

    if (event_take)
    begin
      nxt_st.vec_tgt = {st_ff.vec_base[31:PSR_VEC_LSB],
                        event_vector};
    end

    // Divider: one enable pulse per full count while active
    nxt_st.div_tick = 1'b0;
    if (div_on)
    begin
      if (st_ff.div_cnt == PSR_DIV_LAST)
      begin
        nxt_st.div_cnt  = PSR_DIV_ZERO;
        nxt_st.div_tick = 1'b1;
      end
      else
      begin
        nxt_st.div_cnt = st_ff.div_cnt + PSR_DIV_ONE;
      end
    end
    else
    begin
      nxt_st.div_cnt = PSR_DIV_ZERO;
    end

    if (!nrst)
    begin
      nxt_st            = '0;
      nxt_st.ram_base   = PSR_RAM_RST;
      nxt_st.div_en     = 1'b0;
      nxt_st.div_dyn    = 1'b0;
      nxt_st.osc_tile   = 1'b0;
      nxt_st.osc_periph = 1'b0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    st_ff <= nxt_st;
  end

  assign ps_rdata           = st_ff.rdata;
  assign ps_ack             = st_ff.ack;
  assign ps_err             = st_ff.err;
  assign ram_base_addr      = st_ff.ram_base;
  assign vector_target_addr = st_ff.vec_tgt;
  assign div_active         = div_on;
  // Full-rate enable when the divider is idle
  assign tile_clk_en        = div_on ? st_ff.div_tick : 1'b1;
  assign osc_tile_run       = st_ff.osc_tile;
  assign osc_periph_run     = st_ff.osc_periph;

endmodule // psr_status_bank

// [hdl/psr_pkg.sv]
// Processor status register bank: offsets, fields, reset values.
// Shared by the bank and its oscillator counter; no other dependency.
package psr_pkg;

  // Register numbers
  localparam logic [7:0]  PSR_RAM_BASE    = 8'h00;
  localparam logic [7:0]  PSR_VEC_BASE    = 8'h01;
  localparam logic [7:0]  PSR_TILE_CTRL   = 8'h02;
  localparam logic [7:0]  PSR_BOOT_STAT   = 8'h03;
  localparam logic [7:0]  PSR_SEC_CFG     = 8'h05;
  localparam logic [7:0]  PSR_OSC_CTRL    = 8'h06;
  localparam logic [7:0]  PSR_OSC_TCELL   = 8'h07;
  localparam logic [7:0]  PSR_OSC_TWIRE   = 8'h08;
  localparam logic [7:0]  PSR_OSC_PCELL   = 8'h09;
  localparam logic [7:0]  PSR_OSC_PWIRE   = 8'h0a;
  localparam logic [7:0]  PSR_SAVED_STAT  = 8'h10;

  // Resource identifier layout
  localparam logic [7:0]  PSR_RES_TAG     = 8'h0c;
  localparam int          PSR_RES_NUM_LSB = 8;

  // Reset values and write masks
  localparam logic [31:0] PSR_RAM_RST     = 32'h0001_0000;
  localparam logic [31:0] PSR_RAM_WMASK   = 32'hffff_fffc;
  localparam logic [31:0] PSR_VEC_WMASK   = 32'hffff_0000;
  localparam logic [31:0] PSR_ZERO        = 32'h0000_0000;

  // Field positions
  localparam int          PSR_DIV_EN_BIT  = 4;
  localparam int          PSR_DIV_DYN_BIT = 5;
  localparam int          PSR_TILE_LSB    = 16;
  localparam int          PSR_OTP_BIT     = 8;
  localparam int          PSR_PINS_LSB    = 0;
  localparam int          PSR_OSC_T_BIT   = 1;
  localparam int          PSR_OSC_P_BIT   = 0;
  localparam int          PSR_VEC_LSB     = 16;

  // Oscillator counters
  localparam int          PSR_NUM_OSC     = 4;
  localparam int          PSR_CNT_W       = 16;
  localparam logic [15:0] PSR_CNT_ONE     = 16'h0001;
  localparam logic [15:0] PSR_CNT_ZERO    = 16'h0000;

  // Power-saving divider: one tile clock enable every 8 core clocks
  localparam int          PSR_DIV_W       = 3;
  localparam logic [2:0]  PSR_DIV_LAST    = 3'h7;
  localparam logic [2:0]  PSR_DIV_ZERO    = 3'h0;
  localparam logic [2:0]  PSR_DIV_ONE     = 3'h1;

endpackage

// [hdl/psr_ring_counter.sv]
// One ring oscillator counter of the processor status bank.
// Assumes osc_level toggles from a free-running oscillator cell that
// runs at under half the core clock rate.
`timescale 1ns/10ps
module psr_ring_counter
  import psr_pkg::*;
(
  input  wire logic                 core_clk,
  input  wire logic                 nrst,
  input  wire logic                 pwr_on_rst_n,
  input  wire logic                 osc_level,
  input  wire logic                 run,
  output logic [PSR_CNT_W-1:0]      count
);

  typedef struct packed {
    logic                 sync1;
    logic                 sync2;
    logic                 prev;
    logic [PSR_CNT_W-1:0] cnt;
  } psr_cnt_state_t;

  psr_cnt_state_t st_ff;
  psr_cnt_state_t nxt_st;

  always_comb
  begin
    nxt_st       = st_ff;
    // Oscillator is asynchronous: two-stage synchroniser
    nxt_st.sync1 = osc_level;
    nxt_st.sync2 = st_ff.sync1;
    nxt_st.prev  = st_ff.sync2;
    if (run && st_ff.sync2 && !st_ff.prev)
    begin
      nxt_st.cnt = st_ff.cnt + PSR_CNT_ONE;
    end
    if (!nrst)
    begin
      // System reset leaves the count alone; the synchroniser keeps
      // tracking so no false edge follows release
      nxt_st.cnt   = st_ff.cnt;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!pwr_on_rst_n)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign count = st_ff.cnt;

endmodule // psr_ring_counter

// [dv/psr_status_bank_asserts.sv]
// Port checks of the processor status bank.
// Bound to every psr_status_bank instance below.
`timescale 1ns/10ps
module psr_bank_asserts
  import psr_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        nrst,
  input wire logic        ps_rd,
  input wire logic        ps_wr,
  input wire logic [15:0] ps_res_id,
  input wire logic [31:0] ps_wdata,
  input wire logic [31:0] ps_rdata,
  input wire logic        ps_ack,
  input wire logic        ps_err,
  input wire logic [31:0] ram_base_addr,
  input wire logic        event_take,
  input wire logic [15:0] event_vector,
  input wire logic [31:0] vector_target_addr,
  input wire logic        div_active,
  input wire logic        tile_clk_en,
  input wire logic        osc_tile_run,
  input wire logic        osc_periph_run
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  wire req = ps_rd | ps_wr;

  property p_ack; req |=> ps_ack; endproperty
  a_ack: assert property (p_ack) else $error("ack missing");
  property p_tag; req && ps_res_id[7:0] != PSR_RES_TAG
    |=> ps_err && ps_rdata == PSR_ZERO; endproperty
  a_tag: assert property (p_tag) else $error("bad tag accepted");
  property p_map; req && ps_res_id == 16'h040c |=> ps_err; endproperty
  a_map: assert property (p_map) else $error("hole accepted");
  property p_ram; ps_wr && ps_res_id == 16'h000c
    |=> ram_base_addr == ($past(ps_wdata) & PSR_RAM_WMASK); endproperty
  a_ram: assert property (p_ram) else $error("ram base");
  property p_vec; event_take
    |=> vector_target_addr[15:0] == $past(event_vector); endproperty
  a_vec: assert property (p_vec) else $error("vector low half");
  property p_clk; !div_active |-> tile_clk_en; endproperty
  a_clk: assert property (p_clk) else $error("clock gated");
  property p_div; div_active && tile_clk_en ##1 div_active
    |-> !tile_clk_en; endproperty
  a_div: assert property (p_div) else $error("divider pulse");
  property p_run; ps_wr && ps_res_id == 16'h060c
    |=> {osc_tile_run, osc_periph_run} == $past(ps_wdata[1:0]);
  endproperty
  a_run: assert property (p_run) else $error("run bits");

  c_err: cover property (ps_ack && ps_err);
  c_div: cover property (div_active && tile_clk_en);
  c_run: cover property (osc_tile_run || osc_periph_run);
endmodule // psr_bank_asserts

bind psr_status_bank psr_bank_asserts chk_u (
  .core_clk(core_clk), .nrst(nrst), .ps_rd(ps_rd), .ps_wr(ps_wr),
  .ps_res_id(ps_res_id), .ps_wdata(ps_wdata), .ps_rdata(ps_rdata),
  .ps_ack(ps_ack), .ps_err(ps_err), .ram_base_addr(ram_base_addr),
  .event_take(event_take), .event_vector(event_vector),
  .vector_target_addr(vector_target_addr), .div_active(div_active),
  .tile_clk_en(tile_clk_en), .osc_tile_run(osc_tile_run),
  .osc_periph_run(osc_periph_run));

// [dv/psr_cpu_model.sv]
// Processor model issuing status reads and writes.
// Assumes the bank acks one cycle after each request.
`timescale 1ns/10ps
module psr_cpu_model
  import psr_pkg::*;
(
  input  wire logic        core_clk,
  output logic             ps_rd,
  output logic             ps_wr,
  output logic [15:0]      ps_res_id,
  output logic [31:0]      ps_wdata,
  input  wire logic [31:0] ps_rdata,
  input  wire logic        ps_ack,
  input  wire logic        ps_err
);
  initial {ps_rd, ps_wr, ps_res_id, ps_wdata} = '0;

  task automatic xfer(input logic w, input logic [7:0] n,
                      input logic [7:0] t, input logic [31:0] d,
                      output logic [31:0] q, output logic [1:0] r);
    @(posedge core_clk);
    ps_wr <= w;
    ps_rd <= !w;
    ps_res_id <= {n, t};
    ps_wdata <= d;
    @(posedge core_clk);
    ps_wr <= 1'b0;
    ps_rd <= 1'b0;
    // Released lines show a changed pattern
    ps_res_id <= ~{n, t};
    ps_wdata <= ~d;
    // Answer taken at the edge where ack stands
    @(posedge core_clk);
    q = ps_rdata;
    r = {ps_ack, ps_err};
  endtask
endmodule // psr_cpu_model

// [dv/tb_top.sv]
// Self-checking bench of the processor status bank.
// Assumes psr_cpu_model as processor, 40 MHz core clock.
`timescale 1ns/10ps
module tb_top
  import psr_pkg::*;
;
  logic core_clk, nrst, pwr_on_rst_n, ps_rd, ps_wr, ps_ack, ps_err;
  logic event_take, cores_all_paused, div_active, tile_clk_en;
  logic otp_boot_en, boot_select_pin_0, boot_select_pin_1, dbg_enter;
  logic otp_sec_valid, osc_tile_run, osc_periph_run;
  logic [5:0] boot_select_pin_hi;
  logic [3:0] osc_level;
  logic [7:0] tile_number;
  logic [15:0] ps_res_id, event_vector;
  logic [31:0] ps_wdata, ps_rdata, ram_base_addr, vector_target_addr;
  logic [31:0] otp_security_word, saved_status_snapshot, q, keep;
  logic [1:0] r;
  int mismatches, tests_run, n;

  psr_cpu_model cpu_u (.core_clk(core_clk), .ps_rd(ps_rd), .ps_wr(ps_wr),
    .ps_res_id(ps_res_id), .ps_wdata(ps_wdata), .ps_rdata(ps_rdata),
    .ps_ack(ps_ack), .ps_err(ps_err));
  psr_status_bank dut_u (.core_clk(core_clk), .nrst(nrst),
    .pwr_on_rst_n(pwr_on_rst_n), .ps_rd(ps_rd), .ps_wr(ps_wr),
    .ps_res_id(ps_res_id), .ps_wdata(ps_wdata), .ps_rdata(ps_rdata),
    .ps_ack(ps_ack), .ps_err(ps_err), .ram_base_addr(ram_base_addr),
    .event_take(event_take), .event_vector(event_vector),
    .vector_target_addr(vector_target_addr),
    .cores_all_paused(cores_all_paused), .div_active(div_active),
    .tile_clk_en(tile_clk_en), .tile_number(tile_number),
    .otp_boot_en(otp_boot_en), .boot_select_pin_0(boot_select_pin_0),
    .boot_select_pin_1(boot_select_pin_1),
    .boot_select_pin_hi(boot_select_pin_hi),
    .otp_sec_valid(otp_sec_valid), .otp_security_word(otp_security_word),
    .dbg_enter(dbg_enter), .saved_status_snapshot(saved_status_snapshot),
    .osc_level(osc_level), .osc_tile_run(osc_tile_run),
    .osc_periph_run(osc_periph_run));

  always #12.5 core_clk = ~core_clk;
  // Oscillators, unrelated to the core clock
  always #65 osc_level = ~osc_level;

  task automatic report_and_stop;
    if (mismatches == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e)
    begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic cyc(input int c);
    repeat (c) @(posedge core_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    cpu_u.xfer(1'b1, a, PSR_RES_TAG, d, q, r);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    cpu_u.xfer(1'b0, a, PSR_RES_TAG, PSR_ZERO, q, r);
    chk(q, e);
    chk({30'h0, r}, 32'h2);
  endtask

  task automatic bad(input logic [7:0] a, input logic [7:0] t);
    cpu_u.xfer(1'b1, a, t, PSR_ZERO, q, r);
    chk({30'h0, r}, 32'h3);
  endtask

  // Zero flag z set: count must be zero; reserved half always zero
  task automatic cnt(input logic [7:0] a, input logic z);
    cpu_u.xfer(1'b0, a, PSR_RES_TAG, PSR_ZERO, q, r);
    chk({15'h0, (q[15:0] == PSR_CNT_ZERO) ^ z, q[31:16]}, 32'h0);
  endtask

  task automatic sys_reset;
    cyc(1);
    nrst <= 1'b0;
    cyc(2);
    nrst <= 1'b1;
    cyc(1);
  endtask

  initial
  begin
    {core_clk, nrst, pwr_on_rst_n, event_take, event_vector} = '0;
    {cores_all_paused, otp_sec_valid, otp_security_word, dbg_enter} = '0;
    {saved_status_snapshot, osc_level, boot_select_pin_1} = '0;
    {tile_number, otp_boot_en, boot_select_pin_0} = {8'h5a, 2'b11};
    boot_select_pin_hi = 6'h2d;
    cyc(2);
    nrst <= 1'b1;
    pwr_on_rst_n <= 1'b1;
    cyc(2);
    boot_select_pin_0 <= 1'b0;
    rd(PSR_RAM_BASE, PSR_RAM_RST);
    rd(PSR_TILE_CTRL, PSR_ZERO);
    rd(PSR_OSC_CTRL, PSR_ZERO);
    rd(PSR_BOOT_STAT, 32'h005a01b5);
    wr(PSR_BOOT_STAT, 32'hffffffff);
    otp_boot_en <= 1'b0;
    rd(PSR_BOOT_STAT, 32'h005a00b5);
    wr(PSR_RAM_BASE, 32'hffffffff);
    rd(PSR_RAM_BASE, 32'hfffffffc);
    bad(PSR_RAM_BASE, 8'h0d);
    bad(8'h04, PSR_RES_TAG);
    bad(8'h11, PSR_RES_TAG);
    rd(PSR_RAM_BASE, 32'hfffffffc);
    wr(PSR_VEC_BASE, 32'hffffffff);
    rd(PSR_VEC_BASE, PSR_VEC_WMASK);
    cyc(1);
    event_take <= 1'b1;
    event_vector <= 16'h1234;
    cyc(1);
    event_take <= 1'b0;
    @(negedge core_clk);
    chk(vector_target_addr, 32'hffff1234);
    wr(PSR_TILE_CTRL, 32'hffffffff);
    rd(PSR_TILE_CTRL, 32'h30);
    chk({31'h0, div_active}, 32'h0);
    cores_all_paused <= 1'b1;
    @(negedge core_clk);
    chk({31'h0, div_active}, 32'h1);
    @(posedge core_clk);
    cores_all_paused <= 1'b0;
    wr(PSR_TILE_CTRL, 32'h10);
    chk({31'h0, div_active}, 32'h1);
    n = 0;
    repeat (16) @(negedge core_clk) n += tile_clk_en;
    chk(n, 32'h2);
    wr(PSR_TILE_CTRL, PSR_ZERO);
    chk({30'h0, div_active, tile_clk_en}, 32'h1);
    otp_security_word <= 32'ha5c30f96;
    otp_sec_valid <= 1'b1;
    saved_status_snapshot <= 32'h13579bdf;
    dbg_enter <= 1'b1;
    cyc(1);
    {otp_sec_valid, dbg_enter} <= 2'b00;
    wr(PSR_SEC_CFG, PSR_ZERO);
    rd(PSR_SEC_CFG, 32'ha5c30f96);
    wr(PSR_SAVED_STAT, PSR_ZERO);
    rd(PSR_SAVED_STAT, 32'h13579bdf);
    cnt(PSR_OSC_TCELL, 1'b1);
    wr(PSR_OSC_CTRL, 32'h2);
    cyc(60);
    wr(PSR_OSC_CTRL, PSR_ZERO);
    cyc(5);
    cnt(PSR_OSC_TWIRE, 1'b0);
    cnt(PSR_OSC_PCELL, 1'b1);
    cnt(PSR_OSC_TCELL, 1'b0);
    keep = q;
    sys_reset;
    rd(PSR_OSC_TCELL, keep);
    rd(PSR_RAM_BASE, PSR_RAM_RST);
    wr(PSR_OSC_CTRL, 32'hfffffffd);
    rd(PSR_OSC_CTRL, 32'h1);
    cyc(60);
    wr(PSR_OSC_CTRL, PSR_ZERO);
    cyc(5);
    cnt(PSR_OSC_PCELL, 1'b0);
    cnt(PSR_OSC_PWIRE, 1'b0);
    report_and_stop;
  end

  initial
  begin
    #50us;
    mismatches++;
    report_and_stop;
  end
endmodule // tb_top
